// File: rtl/fcsu_pkg.sv
// shared constants and types of the flash command and status unit
package fcsu_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_CLKDIV = 8'h08;
  localparam logic [7:0] OFS_PROTECT = 8'h0c;
  localparam logic [7:0] OFS_ADDR = 8'h10;
  localparam logic [7:0] OFS_WDATA = 8'h14;

  // status bit positions
  localparam int BIT_CBEF = 7;
  localparam int BIT_CCF = 6;
  localparam int BIT_PVIOL = 5;
  localparam int BIT_ACCERR = 4;
  localparam int BIT_BLANK = 2;

  // protect register fields: bit 0 disables protection, 7:1 first protected page
  localparam int BIT_PROT_DIS = 0;
  localparam int PAGE_LSB = 9;

  // command codes
  localparam logic [7:0] CMD_BLANK_CHECK = 8'h05;
  localparam logic [7:0] CMD_BYTE_PROGRAM = 8'h20;
  localparam logic [7:0] CMD_BURST_PROGRAM = 8'h25;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
  localparam logic [7:0] CMD_WHOLE_ERASE = 8'h41;

  // reset values
  localparam logic [7:0] RST_COMMAND = 8'h00;
  localparam logic [7:0] RST_CLKDIV = 8'h00;
  localparam logic [7:0] RST_PROTECT = 8'h01;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [7:0] RST_WDATA = 8'h00;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_EXEC = 2'b10
  } fcsu_state_e;

endpackage : fcsu_pkg

// File: rtl/fcsu_flash_command_status_unit.sv
// flash command launch and status logic with an apb register slave
`timescale 1ns/1ps
`default_nettype none

module fcsu_flash_command_status_unit #(
  parameter int ADDR_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_mode,
  input wire logic arr_done,
  input wire logic arr_erased,
  output logic arr_start,
  output logic [7:0] arr_cmd,
  output logic [ADDR_W-1:0] arr_addr,
  output logic [7:0] arr_wdata
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // code is one of the five recognised commands
  function automatic logic is_legal(input logic [7:0] code);
    is_legal = (code == fcsu_pkg::CMD_BLANK_CHECK) || (code == fcsu_pkg::CMD_BYTE_PROGRAM) ||
               (code == fcsu_pkg::CMD_BURST_PROGRAM) || (code == fcsu_pkg::CMD_PAGE_ERASE) ||
               (code == fcsu_pkg::CMD_WHOLE_ERASE);
  endfunction : is_legal

  // code alters array contents
  function automatic logic is_modify(input logic [7:0] code);
    is_modify = is_legal(code) && (code != fcsu_pkg::CMD_BLANK_CHECK);
  endfunction : is_modify

  // target hits protection: page at or above boundary, or whole erase under any protection
  function automatic logic is_protected(input logic [7:0] code, input logic [7:0] prot,
                                        input logic [ADDR_W-1:0] addr);
    logic [6:0] page;
    page = 7'(addr >> fcsu_pkg::PAGE_LSB);
    if (prot[fcsu_pkg::BIT_PROT_DIS] || !is_modify(code)) begin
      is_protected = 1'b0;
    end else if (code == fcsu_pkg::CMD_WHOLE_ERASE) begin
      is_protected = 1'b1;
    end else begin
      is_protected = (page >= prot[7:1]);
    end
  endfunction : is_protected

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state so every answer comes from a flop

  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic acc_phase;
  logic do_write;
  logic addr_ok;

  assign acc_phase = psel && penable && !pready_ff;
  assign do_write = psel && penable && pready_ff && pwrite && addr_ok;
  assign addr_ok = (paddr == fcsu_pkg::OFS_STATUS) || (paddr == fcsu_pkg::OFS_COMMAND) ||
                   (paddr == fcsu_pkg::OFS_CLKDIV) || (paddr == fcsu_pkg::OFS_PROTECT) ||
                   (paddr == fcsu_pkg::OFS_ADDR) || (paddr == fcsu_pkg::OFS_WDATA);

  // ready rises one cycle into the access phase, then drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= acc_phase;
      pslverr_ff <= acc_phase && !addr_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain configuration registers

  logic [7:0] command_ff;
  logic [7:0] clkdiv_ff;
  logic div_written_ff;
  logic [7:0] protect_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0] wdata_ff;
  logic wr_status;
  logic wr_command;

  assign wr_status = do_write && (paddr == fcsu_pkg::OFS_STATUS);
  assign wr_command = do_write && (paddr == fcsu_pkg::OFS_COMMAND);

  // software-written values feeding the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_ff <= fcsu_pkg::RST_COMMAND;
      clkdiv_ff <= fcsu_pkg::RST_CLKDIV;
      div_written_ff <= 1'b0;
      protect_ff <= fcsu_pkg::RST_PROTECT;
      addr_ff <= ADDR_W'(fcsu_pkg::RST_ADDR);
      wdata_ff <= fcsu_pkg::RST_WDATA;
    end else begin
      if (wr_command) begin
        command_ff <= pwdata[7:0];
      end
      if (do_write && (paddr == fcsu_pkg::OFS_CLKDIV)) begin
        clkdiv_ff <= pwdata[7:0];
        div_written_ff <= 1'b1;
      end
      if (do_write && (paddr == fcsu_pkg::OFS_PROTECT)) begin
        protect_ff <= pwdata[7:0];
      end
      if (do_write && (paddr == fcsu_pkg::OFS_ADDR)) begin
        addr_ff <= pwdata[ADDR_W-1:0];
      end
      if (do_write && (paddr == fcsu_pkg::OFS_WDATA)) begin
        wdata_ff <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // launch checks

  fcsu_pkg::fcsu_state_e state_ff;
  logic cbef_ff;
  logic ccf_ff;
  logic pviol_ff;
  logic accerr_ff;
  logic blank_ff;
  logic cmd_armed_ff;
  logic [7:0] cur_cmd_ff;
  logic [7:0] buf_cmd_ff;
  logic [ADDR_W-1:0] buf_addr_ff;
  logic [7:0] buf_wdata_ff;
  logic busy;
  logic launch_req;
  logic launch_ok;
  logic launch_viol;
  logic seq_err;
  logic stop_err;
  logic transfer;

  assign busy = (state_ff != fcsu_pkg::ST_IDLE);
  // launch only counts while the buffer is empty; otherwise it is a sequence break
  assign launch_req = wr_status && pwdata[fcsu_pkg::BIT_CBEF];

  // a launch fails on any sequence, code, divider or queueing fault
  always_comb begin
    seq_err = 1'b0;
    launch_viol = 1'b0;
    if (launch_req) begin
      if (!cbef_ff || !cmd_armed_ff) begin
        seq_err = 1'b1;
      end else if (!is_legal(command_ff)) begin
        seq_err = 1'b1;
      end else if (is_modify(command_ff) && !div_written_ff) begin
        seq_err = 1'b1;
      end else if (busy && ((command_ff != fcsu_pkg::CMD_BURST_PROGRAM) ||
                            (cur_cmd_ff != fcsu_pkg::CMD_BURST_PROGRAM))) begin
        seq_err = 1'b1;
      end else if (is_protected(command_ff, protect_ff, addr_ff)) begin
        launch_viol = 1'b1;
      end
    end
    // a command written while the buffer is full is out of sequence too
    if (wr_command && !cbef_ff) begin
      seq_err = 1'b1;
    end
    // writing an illegal code is flagged at once
    if (wr_command && !is_legal(pwdata[7:0])) begin
      seq_err = 1'b1;
    end
  end

  assign launch_ok = launch_req && !seq_err && !launch_viol;
  assign stop_err = stop_mode && (busy || !cbef_ff);
  // buffered command moves into the array only when the sequencer is idle
  assign transfer = !cbef_ff && (state_ff == fcsu_pkg::ST_IDLE) && !stop_err;

  // command armed by a legal command write while the buffer is empty, spent by any launch attempt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_armed_ff <= 1'b0;
    end else if (launch_req) begin
      cmd_armed_ff <= 1'b0;
    end else if (wr_command) begin
      cmd_armed_ff <= cbef_ff && is_legal(pwdata[7:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command buffer: one entry, loaded at launch

  // buffer-empty flag; set wins if a transfer or stop meets a launch in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cbef_ff <= 1'b1;
    end else if (transfer || stop_err) begin
      cbef_ff <= 1'b1;
    end else if (launch_ok) begin
      cbef_ff <= 1'b0;
    end
  end

  // captured command, target and data of the launch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_cmd_ff <= fcsu_pkg::RST_COMMAND;
      buf_addr_ff <= ADDR_W'(fcsu_pkg::RST_ADDR);
      buf_wdata_ff <= fcsu_pkg::RST_WDATA;
    end else if (launch_ok) begin
      buf_cmd_ff <= command_ff;
      buf_addr_ff <= addr_ff;
      buf_wdata_ff <= wdata_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer toward the array

  logic arr_start_ff;
  logic [7:0] arr_cmd_ff;
  logic [ADDR_W-1:0] arr_addr_ff;
  logic [7:0] arr_wdata_ff;

  // idle takes a buffered command, start pulses the array, exec waits for done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= fcsu_pkg::ST_IDLE;
      cur_cmd_ff <= fcsu_pkg::RST_COMMAND;
    end else if (stop_err) begin
      state_ff <= fcsu_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        fcsu_pkg::ST_IDLE: begin
          if (transfer) begin
            state_ff <= fcsu_pkg::ST_START;
            cur_cmd_ff <= buf_cmd_ff;
          end
        end
        fcsu_pkg::ST_START: begin
          state_ff <= fcsu_pkg::ST_EXEC;
        end
        fcsu_pkg::ST_EXEC: begin
          if (arr_done) begin
            state_ff <= fcsu_pkg::ST_IDLE;
          end
        end
        default: begin
          state_ff <= fcsu_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // array request lines; the code picks blank check, program or erase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arr_start_ff <= 1'b0;
      arr_cmd_ff <= fcsu_pkg::RST_COMMAND;
      arr_addr_ff <= ADDR_W'(fcsu_pkg::RST_ADDR);
      arr_wdata_ff <= fcsu_pkg::RST_WDATA;
    end else begin
      arr_start_ff <= transfer;
      if (transfer) begin
        arr_cmd_ff <= buf_cmd_ff;
        arr_addr_ff <= buf_addr_ff;
        arr_wdata_ff <= buf_wdata_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  // complete flag follows empty buffer and idle sequencer, dropped at launch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccf_ff <= 1'b1;
    end else if (launch_ok) begin
      ccf_ff <= 1'b0;
    end else begin
      ccf_ff <= cbef_ff && !transfer && (state_ff == fcsu_pkg::ST_IDLE) &&
                !(arr_start_ff);
    end
  end

  // protection flag: hardware set beats a same-cycle one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pviol_ff <= 1'b0;
    end else if (launch_viol) begin
      pviol_ff <= 1'b1;
    end else if (wr_status && pwdata[fcsu_pkg::BIT_PVIOL]) begin
      pviol_ff <= 1'b0;
    end
  end

  // access error flag: set wins over clear, zero written leaves it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accerr_ff <= 1'b0;
    end else if (seq_err || stop_err) begin
      accerr_ff <= 1'b1;
    end else if (wr_status && pwdata[fcsu_pkg::BIT_ACCERR]) begin
      accerr_ff <= 1'b0;
    end
  end

  // blank flag: only a finishing blank check sets it; a launch clears it, other writes never touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_ff <= 1'b0;
    end else if (launch_ok) begin
      blank_ff <= 1'b0;
    end else if ((state_ff == fcsu_pkg::ST_EXEC) && arr_done &&
                 (cur_cmd_ff == fcsu_pkg::CMD_BLANK_CHECK)) begin
      blank_ff <= arr_erased;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the first access cycle

  logic [7:0] status_rd;

  assign status_rd = {cbef_ff, ccf_ff, pviol_ff, accerr_ff, 1'b0, blank_ff, 2'b00};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (acc_phase) begin
      case (paddr)
        fcsu_pkg::OFS_STATUS: prdata_ff <= {24'h00_0000, status_rd};
        fcsu_pkg::OFS_COMMAND: prdata_ff <= {24'h00_0000, command_ff};
        fcsu_pkg::OFS_CLKDIV: prdata_ff <= {24'h00_0000, clkdiv_ff};
        fcsu_pkg::OFS_PROTECT: prdata_ff <= {24'h00_0000, protect_ff};
        fcsu_pkg::OFS_ADDR: prdata_ff <= 32'(addr_ff);
        fcsu_pkg::OFS_WDATA: prdata_ff <= {24'h00_0000, wdata_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign arr_start = arr_start_ff;
  assign arr_cmd = arr_cmd_ff;
  assign arr_addr = arr_addr_ff;
  assign arr_wdata = arr_wdata_ff;

endmodule : fcsu_flash_command_status_unit

`default_nettype wire

// File: bench/fcsu_sva.sv
// bus and array-port assertions for the flash command and status unit
`timescale 1ns/1ps
`default_nettype none
module fcsu_checker #(
  parameter int ADDR_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_mode,
  input wire logic arr_done,
  input wire logic arr_erased,
  input wire logic arr_start,
  input wire logic [7:0] arr_cmd,
  input wire logic [ADDR_W-1:0] arr_addr,
  input wire logic [7:0] arr_wdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  // access phase still waiting, and a completed status read
  sequence access_wait_s;
    psel && penable && !pready;
  endsequence
  sequence status_read_s;
    pready && !pwrite && paddr == fcsu_pkg::OFS_STATUS;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  // exactly one wait state, pulse answers
  ready_answer_a: assert property (access_wait_s |=> pready) else $error("no answer");
  ready_wait_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("answer without wait state");
  ready_pulse_a: assert property (pready |=> !pready) else $error("answer too long");
  unmapped_err_a: assert property (pready && paddr > fcsu_pkg::OFS_WDATA |-> pslverr
    && prdata == 32'h0) else $error("unmapped not refused");
  mapped_ok_a: assert property (pready && paddr <= fcsu_pkg::OFS_WDATA && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("mapped refused");
  status_zero_a: assert property (status_read_s |-> prdata[31:8] == 24'h0 && prdata[3] == 1'b0
    && prdata[1:0] == 2'b00) else $error("reserved status bits set");
  // array launch outputs
  start_pulse_a: assert property (arr_start |=> !arr_start) else $error("start too long");
  start_legal_a: assert property (arr_start |-> arr_cmd inside {8'h05, 8'h20, 8'h25,
    8'h40, 8'h41}) else $error("illegal command started");
  arr_hold_a: assert property (!arr_start |-> $stable(arr_cmd) && $stable(arr_addr)
    && $stable(arr_wdata)) else $error("array outputs moved");
endmodule : fcsu_checker
bind fcsu_flash_command_status_unit fcsu_checker #(.ADDR_W(ADDR_W)) u_fcsu_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stop_mode(stop_mode), .arr_done(arr_done), .arr_erased(arr_erased),
  .arr_start(arr_start), .arr_cmd(arr_cmd), .arr_addr(arr_addr), .arr_wdata(arr_wdata));
`default_nettype wire

// File: bench/fcsu_flash_command_status_unit_bench.sv
// self-checking testbench of the flash command and status unit
`timescale 1ns/1ps
`default_nettype none
module fcsu_flash_command_status_unit_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic stop_mode = 1'b0;
  logic arr_done = 1'b0;
  logic arr_erased = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, arr_start, se, pv, ae, bl;
  logic [7:0] arr_cmd, arr_wdata, wd;
  logic [15:0] arr_addr, a;
  logic [7:0] codes [6] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h05};
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int starts = 0;
  int s0;
  always #5 pclk = ~pclk;
  fcsu_flash_command_status_unit u_fcsu_flash_command_status_unit (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .arr_done(arr_done), .arr_erased(arr_erased),
    .arr_start(arr_start), .arr_cmd(arr_cmd), .arr_addr(arr_addr), .arr_wdata(arr_wdata));
  ////////////////////////////////////////////////////////////////////////
  // start counter and hang guard, generous for about 520 cycles of tests
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (arr_start === 1'b1) starts <= starts + 1;
    if (cyc > 20000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // expected status byte from the flags the bench tracks
  function automatic logic [31:0] st(input logic be, input logic cc);
    return {24'h0, be, cc, pv, ae, 1'b0, bl, 2'b00};
  endfunction : st
  ////////////////////////////////////////////////////////////////////////
  // one apb transfer; an idle edge first so psel is never set twice at once
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; a hung slave is caught by the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic status(input logic be, input logic cc);
    apb(1'b0, fcsu_pkg::OFS_STATUS, 32'h0);
    chk("status", st(be, cc), rd);
  endtask : status
  task automatic launch(input logic [7:0] c, input logic [15:0] ad);
    apb(1'b1, fcsu_pkg::OFS_ADDR, {16'h0, ad});
    wd = 8'($urandom);
    apb(1'b1, fcsu_pkg::OFS_WDATA, {24'h0, wd});
    apb(1'b1, fcsu_pkg::OFS_COMMAND, {24'h0, c});
    apb(1'b1, fcsu_pkg::OFS_STATUS, 32'h80);
    repeat (4) @(posedge pclk);
  endtask : launch
  task automatic done_pulse(input logic er);
    arr_erased <= er;
    arr_done <= 1'b1;
    @(posedge pclk);
    arr_done <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : done_pulse
  // launch, then either expect a start and finish it, or expect a refusal
  task automatic op(input logic [7:0] c, input logic [15:0] ad, input logic er, input logic go);
    s0 = starts;
    launch(c, ad);
    chk("starts", s0 + go, starts);
    if (go) begin
      bl = 1'b0;
      chk("arr_cmd", {24'h0, c}, {24'h0, arr_cmd});
      chk("arr_addr", {16'h0, ad}, {16'h0, arr_addr});
      chk("arr_wdata", {24'h0, wd}, {24'h0, arr_wdata});
      status(1'b1, 1'b0);
      done_pulse(er);
      bl = (c == fcsu_pkg::CMD_BLANK_CHECK) && er;
    end
    status(1'b1, 1'b1);
  endtask : op
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h45bf0c91));
    pv = 1'b0;
    ae = 1'b0;
    bl = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    status(1'b1, 1'b1);
    apb(1'b1, fcsu_pkg::OFS_STATUS, 32'h4f);
    status(1'b1, 1'b1);
    $display("test reset and read-only bits done");
    ae = 1'b1;
    op(fcsu_pkg::CMD_BYTE_PROGRAM, 16'($urandom), 1'b0, 1'b0);
    apb(1'b1, fcsu_pkg::OFS_STATUS, 32'h0);
    status(1'b1, 1'b1);
    ae = 1'b0;
    apb(1'b1, fcsu_pkg::OFS_STATUS, 32'h10);
    status(1'b1, 1'b1);
    apb(1'b1, fcsu_pkg::OFS_CLKDIV, ($urandom & 32'hff) | 32'h1);
    ae = 1'b1;
    op(8'h80 | 8'($urandom), 16'($urandom), 1'b0, 1'b0);
    apb(1'b1, fcsu_pkg::OFS_STATUS, 32'h10);
    ae = 1'b0;
    $display("test access errors done");
    for (int k = 0; k < 6; k++) begin
      op(codes[k], 16'($urandom), (k == 0) ? 1'b1 : (k == 5) ? 1'b0 : 1'($urandom), 1'b1);
    end
    op(fcsu_pkg::CMD_BLANK_CHECK, 16'($urandom), 1'b1, 1'b1);
    apb(1'b1, fcsu_pkg::OFS_STATUS, 32'h44);
    status(1'b1, 1'b1);
    $display("test command codes done");
    apb(1'b1, fcsu_pkg::OFS_PROTECT, 32'h80);
    pv = 1'b1;
    op(fcsu_pkg::CMD_PAGE_ERASE, 16'h8000 | 16'($urandom), 1'b0, 1'b0);
    apb(1'b1, fcsu_pkg::OFS_STATUS, 32'h20);
    pv = 1'b0;
    status(1'b1, 1'b1);
    pv = 1'b1;
    op(fcsu_pkg::CMD_WHOLE_ERASE, 16'h0, 1'b0, 1'b0);
    ae = 1'b1;
    apb(1'b1, fcsu_pkg::OFS_COMMAND, 32'hff);
    apb(1'b1, fcsu_pkg::OFS_STATUS, 32'h20);
    pv = 1'b0;
    status(1'b1, 1'b1);
    apb(1'b1, fcsu_pkg::OFS_STATUS, 32'h10);
    ae = 1'b0;
    apb(1'b1, fcsu_pkg::OFS_PROTECT, 32'h01);
    $display("test protection done");
    s0 = starts;
    bl = 1'b0;
    launch(fcsu_pkg::CMD_BURST_PROGRAM, 16'($urandom));
    a = 16'($urandom);
    launch(fcsu_pkg::CMD_BURST_PROGRAM, a);
    status(1'b0, 1'b0);
    done_pulse(1'b0);
    chk("burst starts", s0 + 2, starts);
    chk("burst addr", {16'h0, a}, {16'h0, arr_addr});
    chk("burst wdata", {24'h0, wd}, {24'h0, arr_wdata});
    status(1'b1, 1'b0);
    done_pulse(1'b0);
    status(1'b1, 1'b1);
    $display("test burst queue done");
    launch(fcsu_pkg::CMD_BYTE_PROGRAM, 16'($urandom));
    stop_mode <= 1'b1;
    @(posedge pclk);
    stop_mode <= 1'b0;
    repeat (4) @(posedge pclk);
    ae = 1'b1;
    status(1'b1, 1'b1);
    // a reset in mid-run drops the sticky error and returns the idle status
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ae = 1'b0;
    status(1'b1, 1'b1);
    apb(1'b1, fcsu_pkg::OFS_STATUS, 32'h10);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, se});
    $display("test stop mode and unmapped done");
    conclude();
  end
endmodule : fcsu_flash_command_status_unit_bench
`default_nettype wire
